// [fpsr_top.sv]
`timescale 1ns/1ps

module fpsr_top (
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	// register read port
	input  wire logic [2:0]  rf_rd_sel,
	input  wire logic        rf_rd_dbl,
	output logic      [63:0] rf_rd_data,
	// status word load and store
	input  wire logic        ld_status_valid,
	input  wire logic [15:0] ld_status_data,
	input  wire logic        st_status_valid,
	output logic      [15:0] st_status_data,
	output logic      [1:0]  rounding_select,
	// rounding decision
	input  wire logic        rnd_valid,
	input  wire logic        rnd_sign,
	input  wire logic        rnd_lsb,
	input  wire logic        rnd_guard,
	input  wire logic        rnd_sticky,
	output logic             rnd_up,
	output logic             rnd_inexact,
	// instruction completion
	input  wire logic        ex_done,
	input  wire logic [23:0] ex_instr,
	input  wire logic        ex_is_move,
	input  wire logic        ex_is_div,
	input  wire logic        ex_dbl,
	input  wire logic [63:0] ex_src_a,
	input  wire logic        ex_src_a_fp,
	input  wire logic [63:0] ex_src_b,
	input  wire logic        ex_src_b_fp,
	input  wire logic        ex_dst_fp,
	input  wire logic [2:0]  ex_dst_reg,
	input  wire logic        ex_res_int,
	input  wire logic [1:0]  ex_int_size,
	input  wire logic [63:0] ex_result,
	input  wire logic        ex_overflow,
	input  wire logic        ex_underflow,
	input  wire logic        ex_inexact,
	// outcome
	output logic             trap_req,
	output logic      [2:0]  trap_code,
	output logic             xfer_valid,
	output logic      [63:0] xfer_data
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [31:0] data_regs_ff [fpsr_pkg::NUM_REGS];
	logic [2:0]  trap_type_ff;
	logic        underflow_flag_ff;
	logic        inexact_flag_ff;
	logic        underflow_en_ff;
	logic        inexact_en_ff;
	logic [1:0]  round_sel_ff;
	logic [6:0]  scratch_ff;
	logic [15:0] status_word;
	logic        rnd_up_c;
	logic        rnd_inexact_c;
	logic        rnd_up_ff;
	logic        rnd_inexact_ff;
	logic        trap_req_ff;
	logic [2:0]  trap_code_ff;
	logic        xfer_valid_ff;
	logic [63:0] xfer_data_ff;
	logic [63:0] rf_rd_data_ff;
	logic [15:0] st_status_data_ff;

	// ------------------------------------------------------------
	// exception classification
	// ------------------------------------------------------------
	logic        illegal;
	logic        rsvd_a;
	logic        rsvd_b;
	logic        rsvd_out;
	logic        zero_a;
	logic        zero_b;
	logic        invalid;
	logic        divzero;
	logic        int_ovf;
	logic        overflow;
	logic [2:0]  nxt_code;
	logic        trap_take;
	logic        deliver;
	logic        fp_write;
	logic [2:0]  wr_even;
	logic [63:0] deliver_data;
	logic [63:0] int_ext;

	function automatic logic [63:0] sign_ext(input logic [63:0] v, input logic [1:0] sz);
		case (sz)
			fpsr_pkg::INT_BYTE:  sign_ext = {{56{v[7]}}, v[7:0]};
			fpsr_pkg::INT_WORD:  sign_ext = {{48{v[15]}}, v[15:0]};
			default:             sign_ext = {{32{v[31]}}, v[31:0]};
		endcase
	endfunction : sign_ext

	assign illegal = (ex_instr[7:0] == fpsr_pkg::ILL_LOW_BYTE)
		&& ((ex_instr[13:10] == fpsr_pkg::ILL_PAT_A)
		|| (ex_instr[13:10] == fpsr_pkg::ILL_PAT_B));                 // [RULE_14]
	assign rsvd_a   = ex_src_a_fp && fpsr_pkg::is_reserved(ex_src_a, ex_dbl); // [RULE_21]
	assign rsvd_b   = ex_src_b_fp && fpsr_pkg::is_reserved(ex_src_b, ex_dbl); // [RULE_21]
	// overflow or divide by zero may leave an infinity here, reported under its own code
	assign rsvd_out = !ex_is_move && !ex_res_int && !ex_underflow && !ex_overflow
		&& !(ex_is_div && zero_b) && fpsr_pkg::is_reserved(ex_result, ex_dbl); // [RULE_22]
	assign zero_a   = fpsr_pkg::is_zero(ex_src_a, ex_dbl);
	assign zero_b   = fpsr_pkg::is_zero(ex_src_b, ex_dbl);
	assign divzero  = ex_is_div && zero_b && !zero_a;                // [RULE_13]
	assign invalid  = (!ex_is_move && (rsvd_a || rsvd_b))            // [RULE_15] [RULE_22]
		|| (ex_is_div && zero_a && zero_b)                           // [RULE_13]
		|| rsvd_out;
	assign int_ext  = sign_ext(ex_result, ex_int_size);              // [RULE_04]
	assign int_ovf  = ex_res_int && (int_ext != ex_result);          // [RULE_12]
	assign overflow = ex_overflow || int_ovf;                        // [RULE_12]

	always_comb begin
		if (illegal) begin
			nxt_code = fpsr_pkg::TRAP_ILLEGAL;                       // [RULE_11]
		end else if (invalid) begin
			nxt_code = fpsr_pkg::TRAP_INVALID;
		end else if (divzero) begin
			nxt_code = fpsr_pkg::TRAP_DIVZERO;
		end else if (overflow) begin
			nxt_code = fpsr_pkg::TRAP_OVERFLOW;
		end else if (ex_underflow) begin
			nxt_code = fpsr_pkg::TRAP_UNDERFLOW;                     // [RULE_10]
		end else if (ex_inexact) begin
			nxt_code = fpsr_pkg::TRAP_INEXACT;                       // [RULE_10] [RULE_16]
		end else begin
			nxt_code = fpsr_pkg::TRAP_NONE;                          // [RULE_09]
		end
	end

	always_comb begin
		case (nxt_code)
			fpsr_pkg::TRAP_NONE:      trap_take = 1'b0;
			fpsr_pkg::TRAP_UNDERFLOW: trap_take = underflow_en_ff;  // [RULE_07]
			fpsr_pkg::TRAP_INEXACT:   trap_take = inexact_en_ff;    // [RULE_08]
			default:                  trap_take = 1'b1;
		endcase
	end

	// quiet underflow delivers positive zero, quiet inexact the rounded result
	assign deliver      = ex_done && !trap_take;
	assign deliver_data = (nxt_code == fpsr_pkg::TRAP_UNDERFLOW) ? 64'h0 : ex_result; // [RULE_07] [RULE_08]
	assign fp_write     = deliver && ex_dst_fp && !ex_res_int;                        // [RULE_01]
	assign wr_even      = {ex_dst_reg[2:1], 1'b0};                                    // [RULE_02]

	// ------------------------------------------------------------
	// data registers
	// ------------------------------------------------------------
	generate
		for (genvar g = 0; g < fpsr_pkg::NUM_REGS; g++) begin : g_reg
			always_ff @(posedge sys_clk or negedge rst_b) begin
				if (!rst_b) begin
					data_regs_ff[g] <= fpsr_pkg::DATA_RESET;
				end else if (fp_write) begin
					if (!ex_dbl && (ex_dst_reg == 3'(g))) begin
						data_regs_ff[g] <= deliver_data[31:0];       // [RULE_01]
					end else if (ex_dbl && (wr_even == 3'(g))) begin
						data_regs_ff[g] <= deliver_data[31:0];       // [RULE_02]
					end else if (ex_dbl && ((wr_even | 3'h1) == 3'(g))) begin
						data_regs_ff[g] <= deliver_data[63:32];      // [RULE_02]
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rf_rd_data_ff <= 64'h0;
		end else if (rf_rd_dbl) begin
			rf_rd_data_ff <= {data_regs_ff[{rf_rd_sel[2:1], 1'b1}],
				data_regs_ff[{rf_rd_sel[2:1], 1'b0}]};               // [RULE_02]
		end else begin
			rf_rd_data_ff <= {32'h0, data_regs_ff[rf_rd_sel]};       // [RULE_01]
		end
	end

	// ------------------------------------------------------------
	// status word
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			trap_type_ff <= fpsr_pkg::STATUS_RESET[fpsr_pkg::TRAP_MSB:fpsr_pkg::TRAP_LSB]; // [RULE_09]
		end else if (ex_done) begin
			trap_type_ff <= nxt_code;                                // [RULE_09] [RULE_10]
		end else if (ld_status_valid && (ld_status_data[fpsr_pkg::TRAP_MSB:fpsr_pkg::TRAP_LSB]
				!= fpsr_pkg::TRAP_RESERVED)) begin
			trap_type_ff <= ld_status_data[fpsr_pkg::TRAP_MSB:fpsr_pkg::TRAP_LSB]; // [RULE_09] [RULE_23]
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			underflow_flag_ff <= fpsr_pkg::STATUS_RESET[fpsr_pkg::UNDERFLOW_FLAG_BIT];
			inexact_flag_ff   <= fpsr_pkg::STATUS_RESET[fpsr_pkg::INEXACT_FLAG_BIT];
		end else begin
			// a hardware set in the same cycle as a zero write wins
			underflow_flag_ff <= (ex_done && ex_underflow)
				|| (ld_status_valid ? ld_status_data[fpsr_pkg::UNDERFLOW_FLAG_BIT]
				: underflow_flag_ff);                                // [RULE_17]
			inexact_flag_ff <= (ex_done && (nxt_code == fpsr_pkg::TRAP_INEXACT))
				|| (ld_status_valid ? ld_status_data[fpsr_pkg::INEXACT_FLAG_BIT]
				: inexact_flag_ff);                                  // [RULE_16] [RULE_18]
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			underflow_en_ff <= fpsr_pkg::STATUS_RESET[fpsr_pkg::UNDERFLOW_EN_BIT];
			inexact_en_ff   <= fpsr_pkg::STATUS_RESET[fpsr_pkg::INEXACT_EN_BIT];
			round_sel_ff    <= fpsr_pkg::STATUS_RESET[fpsr_pkg::ROUND_MSB:fpsr_pkg::ROUND_LSB];
			scratch_ff      <= fpsr_pkg::STATUS_RESET[fpsr_pkg::SCRATCH_MSB:fpsr_pkg::SCRATCH_LSB];
		end else if (ld_status_valid) begin
			underflow_en_ff <= ld_status_data[fpsr_pkg::UNDERFLOW_EN_BIT];  // [RULE_07]
			inexact_en_ff   <= ld_status_data[fpsr_pkg::INEXACT_EN_BIT];    // [RULE_08]
			round_sel_ff    <= ld_status_data[fpsr_pkg::ROUND_MSB:fpsr_pkg::ROUND_LSB]; // [RULE_05]
			scratch_ff      <= ld_status_data[fpsr_pkg::SCRATCH_MSB:fpsr_pkg::SCRATCH_LSB]; // [RULE_19]
		end
	end

	assign status_word = {scratch_ff, round_sel_ff, inexact_flag_ff, inexact_en_ff,
		underflow_flag_ff, underflow_en_ff, trap_type_ff};

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_status_data_ff <= fpsr_pkg::STATUS_RESET;
		end else if (st_status_valid) begin
			st_status_data_ff <= status_word;                        // [RULE_19]
		end
	end

	// ------------------------------------------------------------
	// rounding decision
	// ------------------------------------------------------------
	fpsr_round_unit u_round (
		.mode     (round_sel_ff),
		.sign     (rnd_sign),
		.lsb      (rnd_lsb),
		.guard    (rnd_guard),
		.sticky   (rnd_sticky),
		.round_up (rnd_up_c),
		.inexact  (rnd_inexact_c)
	);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rnd_up_ff      <= 1'b0;
			rnd_inexact_ff <= 1'b0;
		end else if (rnd_valid) begin
			rnd_up_ff      <= rnd_up_c;                              // [RULE_05] [RULE_06]
			rnd_inexact_ff <= rnd_inexact_c;
		end
	end

	// ------------------------------------------------------------
	// outcome and host transfer
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			trap_req_ff  <= 1'b0;
			trap_code_ff <= fpsr_pkg::TRAP_NONE;
		end else begin
			trap_req_ff  <= ex_done && trap_take;                    // [RULE_07] [RULE_08]
			trap_code_ff <= ex_done ? nxt_code : trap_code_ff;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			xfer_valid_ff <= 1'b0;
			xfer_data_ff  <= 64'h0;
		end else begin
			xfer_valid_ff <= deliver && (ex_res_int || !ex_dst_fp);  // [RULE_03]
			if (deliver && ex_res_int) begin
				xfer_data_ff <= int_ext;                             // [RULE_03] [RULE_04]
			end else if (deliver && !ex_dst_fp) begin
				xfer_data_ff <= deliver_data;
			end
		end
	end

	assign rf_rd_data      = rf_rd_data_ff;
	assign st_status_data  = st_status_data_ff;
	assign rounding_select = round_sel_ff;
	assign rnd_up          = rnd_up_ff;
	assign rnd_inexact     = rnd_inexact_ff;
	assign trap_req        = trap_req_ff;
	assign trap_code       = trap_code_ff;
	assign xfer_valid      = xfer_valid_ff;
	assign xfer_data       = xfer_data_ff;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_quiet_underflow;
		ex_done && (nxt_code == fpsr_pkg::TRAP_UNDERFLOW) && !underflow_en_ff
			&& fp_write && !ex_dbl;
	endsequence

	sequence s_other_with_inexact;
		ex_done && ex_inexact && (nxt_code != fpsr_pkg::TRAP_INEXACT)
			&& !ld_status_valid;
	endsequence

	a_clean_clears_code : assert property ( // [RULE_09]
		ex_done && !illegal && !invalid && !divzero && !overflow && !ex_underflow
			&& !ex_inexact |=> (trap_type_ff == 3'h0) && !trap_req)
		else $error("clean completion left trap type set");

	a_underflow_quiet_zero : assert property ( // [RULE_07]
		s_quiet_underflow |=> !trap_req && (trap_type_ff == 3'h1)
			&& (data_regs_ff[$past(ex_dst_reg)] == 32'h0))
		else $error("quiet underflow did not deliver positive zero");

	a_inexact_trap_gate : assert property ( // [RULE_08]
		ex_done && (nxt_code == fpsr_pkg::TRAP_INEXACT) |=> trap_req == $past(inexact_en_ff))
		else $error("inexact trap request does not follow its enable");

	a_other_keeps_inexact : assert property ( // [RULE_16]
		s_other_with_inexact |=> (inexact_flag_ff == $past(inexact_flag_ff))
			&& (trap_type_ff != 3'h6))
		else $error("inexact flag or code changed beside another exception");

	a_underflow_sticky : assert property ( // [RULE_17]
		ex_done && ex_underflow |=> underflow_flag_ff ##1 (underflow_flag_ff || $past(ld_status_valid)))
		else $error("underflow flag not sticky");

	a_divzero_code : assert property ( // [RULE_13]
		ex_done && ex_is_div && !illegal && !rsvd_a && !rsvd_b && zero_b
			|=> trap_type_ff == ($past(zero_a) ? 3'h5 : 3'h3))
		else $error("divide by zero coded wrongly");

	a_illegal_code : assert property ( // [RULE_14]
		ex_done && (ex_instr[7:0] == 8'hbe) && (ex_instr[13:10] == 4'h9)
			|=> (trap_type_ff == 3'h4) && trap_req)
		else $error("illegal pattern not reported");

	a_no_reserved_code : assert property ( // [RULE_23]
		trap_type_ff != 3'h7)
		else $error("reserved trap type stored");

	a_pair_read : assert property ( // [RULE_02]
		rf_rd_dbl && !fp_write |=> rf_rd_data[63:32] == data_regs_ff[{$past(rf_rd_sel[2:1]), 1'b1}])
		else $error("double read pair mismatch");

	a_scratch_hold : assert property ( // [RULE_19]
		ld_status_valid ##1 (!ld_status_valid)[*2] |-> scratch_ff == $past(ld_status_data[15:9], 2))
		else $error("scratch field not kept");

	a_round_tie_even : assert property ( // [RULE_06]
		rnd_valid && (round_sel_ff == 2'h0) && rnd_guard && !rnd_sticky |=> rnd_up == $past(rnd_lsb))
		else $error("tie not rounded to even");

	a_move_passes : assert property ( // [RULE_22]
		ex_done && ex_is_move && !illegal && !overflow && !ex_underflow && !ex_inexact
			|=> trap_type_ff == 3'h0)
		else $error("plain move trapped");

endmodule : fpsr_top

// [fpsr_round_unit.sv]
// Function
// RULE_01 - eight 32-bit data registers, used for register-mode float operands
// RULE_02 - double operand uses even/odd pair; even holds low half, odd high half
// RULE_03 - integer register operands are host registers, moved like memory operands
// RULE_04 - integer operands are two's complement bytes, words or double words
// RULE_05 - rounding select bits 7-8: nearest, zero, plus infinity, minus infinity
// RULE_06 - nearest mode breaks exact ties toward even lsb
// RULE_07 - underflow traps when enabled, else positive zero and no trap
// RULE_08 - inexact traps when enabled, else rounded result delivered without trap
// RULE_09 - trap type cleared on clean completion, reset, or software zero write
// RULE_10 - underflow and inexact always recorded in trap type; code records them only when no higher-priority exception is coded
// RULE_11 - trap type codes 000 to 110, 111 reserved
// RULE_12 - overflow when float or integer result exceeds destination range
// RULE_13 - nonzero divided by zero is divide by zero; zero by zero is invalid
// RULE_14 - two undefined instruction patterns report illegal instruction
// RULE_15 - any reserved float operand reports invalid operation; code exempts plain moves
// RULE_16 - other exception beats inexact; inexact flag then left unchanged
// RULE_17 - sticky underflow flag bit 4, cleared only by reset or zero write
// RULE_18 - sticky inexact flag bit 6 when rounding and no other error
// RULE_19 - bits 9-15 are scratch, stored and read back only
// RULE_20 - host keeps memory operands lsb first, immediates msb first
// RULE_21 - reserved operand: exponent all ones, or zero exponent with nonzero fraction
// RULE_22 - plain move passes reserved operands; reserved results never produced
// RULE_23 - reserved trap type code never loaded
`timescale 1ns/1ps

package fpsr_pkg;
	localparam int unsigned NUM_REGS           = 8;
	localparam int unsigned REG_W              = 32;
	localparam int unsigned STATUS_W           = 16;
	localparam int unsigned TRAP_LSB           = 0;
	localparam int unsigned TRAP_MSB           = 2;
	localparam int unsigned UNDERFLOW_EN_BIT   = 3;
	localparam int unsigned UNDERFLOW_FLAG_BIT = 4;
	localparam int unsigned INEXACT_EN_BIT     = 5;
	localparam int unsigned INEXACT_FLAG_BIT   = 6;
	localparam int unsigned ROUND_LSB          = 7;
	localparam int unsigned ROUND_MSB          = 8;
	localparam int unsigned SCRATCH_LSB        = 9;
	localparam int unsigned SCRATCH_MSB        = 15;
	localparam logic [15:0] STATUS_RESET       = 16'h0000;
	localparam logic [31:0] DATA_RESET         = 32'h0000_0000;
	localparam logic [3:0]  ILL_PAT_A          = 4'h3;
	localparam logic [3:0]  ILL_PAT_B          = 4'h9;
	localparam logic [7:0]  ILL_LOW_BYTE       = 8'hbe;

	typedef enum logic [2:0] {
		TRAP_NONE      = 3'h0,
		TRAP_UNDERFLOW = 3'h1,
		TRAP_OVERFLOW  = 3'h2,
		TRAP_DIVZERO   = 3'h3,
		TRAP_ILLEGAL   = 3'h4,
		TRAP_INVALID   = 3'h5,
		TRAP_INEXACT   = 3'h6,
		TRAP_RESERVED  = 3'h7
	} fpsr_trap_type;

	typedef enum logic [1:0] {
		RND_NEAREST = 2'h0,
		RND_ZERO    = 2'h1,
		RND_POS     = 2'h2,
		RND_NEG     = 2'h3
	} fpsr_round_type;

	typedef enum logic [1:0] {
		INT_BYTE  = 2'h0,
		INT_WORD  = 2'h1,
		INT_DWORD = 2'h2
	} fpsr_int_size_type;

	// exponent all ones, or zero exponent with nonzero fraction
	function automatic logic is_reserved(input logic [63:0] v, input logic dbl);
		logic [10:0] e;
		logic        fz;
		e  = dbl ? v[62:52] : {3'h0, v[30:23]};
		fz = dbl ? (v[51:0] == 52'h0) : (v[22:0] == 23'h0);
		if (dbl) begin
			is_reserved = (e == 11'h7ff) || ((e == 11'h000) && !fz);
		end else begin
			is_reserved = (e[7:0] == 8'hff) || ((e[7:0] == 8'h00) && !fz);
		end
	endfunction : is_reserved

	function automatic logic is_zero(input logic [63:0] v, input logic dbl);
		is_zero = dbl ? (v[62:0] == 63'h0) : (v[30:0] == 31'h0);
	endfunction : is_zero
endpackage : fpsr_pkg

module fpsr_round_unit (
	input  wire logic [1:0] mode,
	input  wire logic       sign,
	input  wire logic       lsb,
	input  wire logic       guard,
	input  wire logic       sticky,
	output logic            round_up,
	output logic            inexact
);
	always_comb begin
		inexact = guard | sticky;
		case (mode)
			fpsr_pkg::RND_NEAREST: round_up = guard & (sticky | lsb); // [RULE_05] [RULE_06]
			fpsr_pkg::RND_ZERO:    round_up = 1'b0;                   // [RULE_05]
			fpsr_pkg::RND_POS:     round_up = ~sign & inexact;        // [RULE_05]
			fpsr_pkg::RND_NEG:     round_up = sign & inexact;         // [RULE_05]
			default:               round_up = 1'b0;
		endcase
	end
endmodule : fpsr_round_unit

// [fpsr_host_model.sv]
`timescale 1ns/1ps

module fpsr_host_model (
	input  wire logic        sys_clk,
	output logic             ld_status_valid,
	output logic      [15:0] ld_status_data,
	output logic             st_status_valid,
	output logic             ex_done,
	output logic      [23:0] ex_instr
);
	// ----------------------------
	// host side of the status path
	// ----------------------------
	initial begin
		{ld_status_valid, st_status_valid, ex_done} = 3'h0;
		ld_status_data = 16'h0000;
		ex_instr       = 24'h000000;
	end

	// status word moves as a memory operand, low byte first
	task automatic load_status(input logic [7:0] lo, input logic [7:0] hi);
		@(posedge sys_clk);
		#1;
		ld_status_data  = {hi, lo};
		ld_status_valid = 1'b1;
		@(posedge sys_clk);
		#1;
		ld_status_valid = 1'b0;
		ld_status_data  = ~ld_status_data;
	endtask : load_status

	task automatic store_status();
		@(posedge sys_clk);
		#1;
		st_status_valid = 1'b1;
		@(posedge sys_clk);
		#1;
		st_status_valid = 1'b0;
	endtask : store_status

	task automatic issue(input logic [23:0] ins);
		@(posedge sys_clk);
		#1;
		ex_instr = ins;
		ex_done  = 1'b1;
		@(posedge sys_clk);
		#1;
		ex_done  = 1'b0;
		ex_instr = ~ins;
	endtask : issue
endmodule : fpsr_host_model

// [test_fp_status_and_register_file.sv]
`timescale 1ns/1ps

module test_fp_status_and_register_file;
	logic        sys_clk, rst_b, rf_rd_dbl, ld_status_valid, st_status_valid, ex_done;
	logic        rnd_valid, rnd_sign, rnd_lsb, rnd_guard, rnd_sticky, rnd_up, rnd_inexact;
	logic        ex_is_move, ex_is_div, ex_dbl, ex_src_a_fp, ex_src_b_fp, ex_dst_fp;
	logic        ex_res_int, ex_overflow, ex_underflow, ex_inexact, trap_req, xfer_valid;
	logic [1:0]  ex_int_size, rounding_select;
	logic [2:0]  rf_rd_sel, ex_dst_reg, trap_code;
	logic [15:0] ld_status_data, st_status_data;
	logic [23:0] ex_instr;
	logic [63:0] rf_rd_data, ex_src_a, ex_src_b, ex_result, xfer_data;
	int          error_cnt, cmp_count;
	localparam logic [63:0] ONE = 64'h3f80_0000;
	localparam logic [63:0] RES = 64'h4000_0000;

	fpsr_top i_dut (.sys_clk, .rst_b, .rf_rd_sel, .rf_rd_dbl, .rf_rd_data, .ld_status_valid,
		.ld_status_data, .st_status_valid, .st_status_data, .rounding_select, .rnd_valid,
		.rnd_sign, .rnd_lsb, .rnd_guard, .rnd_sticky, .rnd_up, .rnd_inexact, .ex_done,
		.ex_instr, .ex_is_move, .ex_is_div, .ex_dbl, .ex_src_a, .ex_src_a_fp, .ex_src_b,
		.ex_src_b_fp, .ex_dst_fp, .ex_dst_reg, .ex_res_int, .ex_int_size, .ex_result,
		.ex_overflow, .ex_underflow, .ex_inexact, .trap_req, .trap_code, .xfer_valid,
		.xfer_data);

	fpsr_host_model i_host (.sys_clk, .ld_status_valid, .ld_status_data, .st_status_valid,
		.ex_done, .ex_instr);

	always #2.5 sys_clk = ~sys_clk;

	// ----------------
	// shared utilities
	// ----------------
	task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic rd(input logic [2:0] sel, input logic dbl, input logic [63:0] exp);
		rf_rd_sel = sel;
		rf_rd_dbl = dbl;
		@(posedge sys_clk);
		#1;
		chk("rf_rd_data", exp, rf_rd_data);
	endtask : rd

	task automatic st_chk(input logic [15:0] exp);
		i_host.store_status();
		chk("st_status_data", 64'(exp), 64'(st_status_data));
	endtask : st_chk

	// f is {move, divide, overflow, underflow, inexact}
	task automatic ex_chk(input logic [4:0] f, input logic [23:0] ins, input logic [63:0] a,
		input logic [63:0] b, input logic [2:0] code, input logic req);
		{ex_is_move, ex_is_div, ex_overflow, ex_underflow, ex_inexact} = f;
		ex_src_a = a;
		ex_src_b = b;
		i_host.issue(ins);
		chk("trap_code", 64'(code), 64'(trap_code));
		chk("trap_req", 64'(req), 64'(trap_req));
	endtask : ex_chk

	task automatic test_done();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : test_done

	// ---------
	// scenarios
	// ---------
	task automatic t_round();
		logic e;
		for (int m = 0; m < 4; m++) begin
			i_host.load_status({m[0], 7'h00}, {7'h00, m[1]});
			chk("rounding_select", 64'(m[1:0]), 64'(rounding_select));
			rnd_valid = 1'b1;
			for (int v = 0; v < 16; v++) begin
				{rnd_sign, rnd_lsb, rnd_guard, rnd_sticky} = v[3:0];
				@(posedge sys_clk);
				#1;
				case (m)
					0: e = rnd_guard & (rnd_sticky | rnd_lsb);
					1: e = 1'b0;
					2: e = !rnd_sign & (rnd_guard | rnd_sticky);
					default: e = rnd_sign & (rnd_guard | rnd_sticky);
				endcase
				chk("rnd_up", 64'(e), 64'(rnd_up));
				chk("rnd_inexact", 64'(rnd_guard | rnd_sticky), 64'(rnd_inexact));
			end
			rnd_valid = 1'b0;
		end
	endtask : t_round

	task automatic t_codes();
		i_host.load_status(8'h80, 8'hfd);
		st_chk(16'hfd80);
		i_host.load_status(8'h00, 8'h00);
		ex_chk(5'h02, 24'h0, ONE, ONE, 3'h1, 1'b0);
		rd(3'h1, 1'b0, 64'h0);
		st_chk(16'h0011);
		ex_chk(5'h00, 24'h0, ONE, ONE, 3'h0, 1'b0);
		st_chk(16'h0010);
		ex_chk(5'h01, 24'h0, ONE, ONE, 3'h6, 1'b0);
		rd(3'h1, 1'b0, RES);
		st_chk(16'h0056);
		i_host.load_status(8'h28, 8'h00);
		ex_chk(5'h02, 24'h0, ONE, ONE, 3'h1, 1'b1);
		ex_chk(5'h01, 24'h0, ONE, ONE, 3'h6, 1'b1);
		i_host.load_status(8'h00, 8'h00);
		ex_chk(5'h05, 24'h0, ONE, ONE, 3'h2, 1'b1);
		st_chk(16'h0002);
		ex_chk(5'h08, 24'h0, ONE, 64'h0, 3'h3, 1'b1);
		ex_result = 64'h7f80_0000;
		ex_chk(5'h08, 24'h0, ONE, 64'h0, 3'h3, 1'b1);
		ex_result = RES;
		ex_chk(5'h08, 24'h0, 64'h0, 64'h0, 3'h5, 1'b1);
		ex_chk(5'h00, 24'h000cbe, ONE, ONE, 3'h4, 1'b1);
		ex_chk(5'h00, 24'h0024be, ONE, ONE, 3'h4, 1'b1);
		ex_chk(5'h10, 24'h0, 64'h7f80_0000, ONE, 3'h0, 1'b0);
		ex_chk(5'h00, 24'h0, ONE, 64'h0000_0001, 3'h5, 1'b1);
		ex_chk(5'h00, 24'h0, 64'h7f80_0000, ONE, 3'h5, 1'b1);
		i_host.load_status(8'h07, 8'h00);
		st_chk(16'h0005);
		i_host.load_status(8'h00, 8'h00);
		st_chk(16'h0000);
	endtask : t_codes

	task automatic t_int();
		ex_res_int = 1'b1;
		ex_dst_fp  = 1'b0;
		for (int s = 0; s < 3; s++) begin
			ex_int_size = 2'(s);
			ex_result   = -(64'h1 << ((8 << s) - 1));
			ex_chk(5'h00, 24'h0, ONE, ONE, 3'h0, 1'b0);
			chk("xfer_valid", 64'h1, 64'(xfer_valid));
			chk("xfer_data", ex_result, xfer_data);
			ex_result = 64'h1 << ((8 << s) - 1);
			ex_chk(5'h00, 24'h0, ONE, ONE, 3'h2, 1'b1);
			chk("xfer_valid", 64'h0, 64'(xfer_valid));
		end
		ex_res_int = 1'b0;
		ex_dst_fp  = 1'b1;
	endtask : t_int

	task automatic t_pair();
		ex_dbl     = 1'b1;
		ex_dst_reg = 3'h3;
		ex_result  = 64'h1111_2222_3333_4444;
		ex_chk(5'h00, 24'h0, 64'h3ff0_0000_0000_0000, 64'h3ff0_0000_0000_0000, 3'h0,
			1'b0);
		rd(3'h2, 1'b1, ex_result);
		rd(3'h3, 1'b1, ex_result);
		rd(3'h2, 1'b0, 64'h3333_4444);
		rd(3'h3, 1'b0, 64'h1111_2222);
	endtask : t_pair

	initial begin
		error_cnt = 0;
		cmp_count = 0;
		sys_clk   = 1'b0;
		rst_b     = 1'b0;
		{rf_rd_dbl, rnd_valid, rnd_sign, rnd_lsb, rnd_guard, rnd_sticky} = 6'h00;
		{ex_is_move, ex_is_div, ex_dbl, ex_res_int, ex_overflow, ex_underflow} = 6'h00;
		{ex_inexact, ex_src_a_fp, ex_src_b_fp, ex_dst_fp} = 4'h7;
		{rf_rd_sel, ex_dst_reg, ex_int_size} = 8'h04;
		ex_src_a  = ONE;
		ex_src_b  = ONE;
		ex_result = RES;
		repeat (2) @(posedge sys_clk);
		#1;
		rst_b = 1'b1;
		st_chk(16'h0000);
		rd(3'h0, 1'b1, 64'h0);
		t_round();
		t_codes();
		t_int();
		t_pair();
		test_done();
	end

	initial begin
		#100000;
		error_cnt++;
		test_done();
	end
endmodule : test_fp_status_and_register_file
